/* verilog/tac_map.svh */
// Register offsets, field positions, limits and timing counts
`ifndef TAC_MAP_SVH
`define TAC_MAP_SVH
`define TAC_ADDR_CTRL       12'h000
`define TAC_ADDR_LOC1       12'h004
`define TAC_ADDR_LOC2       12'h008
`define TAC_ADDR_LOC3       12'h00C
`define TAC_ADDR_LOC4       12'h010
`define TAC_ADDR_KEYS       12'h014
`define TAC_ADDR_STATUS     12'h018
`define TAC_ADDR_LOOPCNT    12'h01C
`define TAC_ADDR_TRACKS     12'h020
`define TAC_CTRL_RETURN     0
`define TAC_CTRL_AUTOPLAY   1
`define TAC_CTRL_AUTOREC    2
`define TAC_CTRL_REHEARSE   3
`define TAC_CTRL_AUTOINPUT  4
`define TAC_KEY_RETURN      0
`define TAC_KEY_AUTOPLAY    1
`define TAC_KEY_AUTOREC     2
`define TAC_KEY_FORMAT      3
`define TAC_KEY_STOP        4
`define TAC_KEY_PLAY        5
`define TAC_KEY_RECPLAY     6
`define TAC_KEY_STORE       7
`define TAC_LOOP_LIMIT      7'd100
`define TAC_MSG_TIME_MS     1500
`define TAC_MSG_CYCLES      ((`TAC_MSG_TIME_MS * 40000) - 1)
`define TAC_FLASH_TIME_MS   250
`define TAC_FLASH_CYCLES    ((`TAC_FLASH_TIME_MS * 40000) - 1)
`define TAC_SLOW_TIME_MS    2000
`define TAC_SLOW_CYCLES     ((`TAC_SLOW_TIME_MS * 40000) - 1)
`define TAC_POS_39MIN       32'h0000_0924
`endif

/* verilog/tac_pkg.sv */
// Types shared by the transport automation controller
package tac_pkg;
  typedef enum logic [2:0] {
    TAC_ST_STOP   = 3'b000,
    TAC_ST_PLAY   = 3'b001,
    TAC_ST_REC    = 3'b010,
    TAC_ST_LOCATE = 3'b011
  } tac_mode_t;
  typedef enum logic [2:0] {
    TAC_MSG_NONE    = 3'b000,
    TAC_MSG_INVALID = 3'b001,
    TAC_MSG_LENGTH  = 3'b010,
    TAC_MSG_LOOPCNT = 3'b011
  } tac_msg_t;
  typedef enum logic [1:0] {
    TAC_LEN_120 = 2'b00,
    TAC_LEN_60  = 2'b01,
    TAC_LEN_160 = 2'b10,
    TAC_LEN_180 = 2'b11
  } tac_len_t;
  typedef struct packed {
    logic        paddr_ok;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } tac_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tac_apb_rsp_t;
  typedef struct packed {
    logic [31:0] position;
    logic        locked;
    logic        locate_done;
    logic        cassette_in;
    logic        large_hub;
  } tac_xport_t;
  typedef struct packed {
    tac_mode_t   mode;
    logic [31:0] locate_target;
    logic        slow;
    logic [7:0]  rec_tracks;
    logic [7:0]  input_mon;
  } tac_cmd_t;
  typedef struct packed {
    logic        return_led;
    logic        record_led;
    tac_msg_t    msg;
    logic [7:0]  msg_value;
  } tac_panel_t;
  typedef struct packed {
    logic [4:0]  ctrl;
    logic [31:0] loc1;
    logic [31:0] loc2;
    logic [31:0] loc3;
    logic [31:0] loc4;
    logic [7:0]  tracks;
    tac_mode_t   mode;
    logic [31:0] target;
    logic        relocate;
    logic [6:0]  loops;
    logic        limit_off;
    logic        loop_dead;
    logic        armed;
    logic        punched;
    tac_len_t    len;
    logic        slowed_once;
    logic [26:0] slow_cnt;
    logic [26:0] msg_cnt;
    tac_msg_t    msg;
    logic [23:0] flash_cnt;
    logic        flash;
    logic        cass_q;
    logic [1:0]  ped_s1;
    logic [1:0]  ped_s2;
    logic [1:0]  ped_rest;
    logic [1:0]  ped_prev;
    logic        calibrated;
    logic [31:0] pos_prev;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    tac_cmd_t    cmd;
    tac_panel_t  panel;
  } tac_state_t;
endpackage

/* verilog/tac_top.sv */
// Transport automation controller: looping, auto record, tape length, pedals
//
// Function
// - Auto return on and position reaches point 4: rewind to point 1.
// - Point 1 after point 4: flash return indicator, never rewind.
// - Auto play on: enter play when any locate finishes.
// - Count consecutive loops; stop looping after 100 unless limit disabled.
// - Store plus return disables loop limit; stop re-enables it.
// - While looping, store plus auto play briefly shows loop count.
// - Auto record refused with brief invalid message if point 2 >= point 3.
// - Armed and playing: flash record indicator; record at point 2, lit steady.
// - No enabled track at point 2: keep flashing, do not record.
// - Track enabled between points 2 and 3 records at once, indicator steady.
// - At point 3 end recording, indicator off, keep playing.
// - Punch-in at point 2 waits for timecode lock.
// - Rehearse with auto input: input monitor at point 2, flash, no record.
// - Without auto input, rehearse does not change monitoring.
// - Store plus format steps length 120, 60, 160, 180 and shows it.
// - Large hub means length 60; small hub uses selected, default 120.
// - Length survives eject; resets to 120 at power-up.
// - Cassette inserted with non-120 length: briefly flash that length.
// - Long tapes: first locate past 39 minutes slows briefly, later ones not.
// - Sample pedal resting levels at power-up; presses relative to those.
// - Punch pedal: play with tracks enters record; recording leaves record.
// - Locate pedal: stopped plays; playing locates to 1; locating stops.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "tac_map.svh"
module tac_top (
  input  wire logic              clk_sys_in,         // 40 MHz system clock
  input  wire logic              arst_n_in,          // Async reset, active low
  input  wire logic              psel_in,            // APB select
  input  wire logic              penable_in,         // APB enable
  input  wire logic              pwrite_in,          // APB write
  input  wire logic [11:0]       paddr_in,           // APB byte address
  input  wire logic [31:0]       pwdata_in,          // APB write data
  output logic      [31:0]       prdata_out,         // APB read data
  output logic                   pready_out,         // APB ready
  output logic                   pslverr_out,        // APB error
  input  wire tac_pkg::tac_xport_t xport_in,         // Transport status
  input  wire logic              punch_pedal_in,     // Punch footswitch pin
  input  wire logic              locate_pedal_input, // Locate/play footswitch pin
  output tac_pkg::tac_cmd_t      cmd_out,            // Transport command
  output tac_pkg::tac_panel_t    panel_out           // Indicators and display
);
  import tac_pkg::*;

  tac_state_t r_reg;
  tac_state_t r_next;

  function automatic logic at_or_past(input logic [31:0] prev, input logic [31:0] cur,
                                      input logic [31:0] pt);
    at_or_past = (prev < pt) && (cur >= pt);
  endfunction

  function automatic logic [7:0] len_code(input tac_len_t l);
    case (l)
      TAC_LEN_60:  len_code = 8'h3C;
      TAC_LEN_160: len_code = 8'hA0;
      TAC_LEN_180: len_code = 8'hB4;
      default:     len_code = 8'h78;
    endcase
  endfunction

  logic        wr;
  logic        rd;
  logic [7:0]  key;
  logic        punch_press;
  logic        locate_press;
  logic        hit1;
  logic        hit2;
  logic        hit3;
  logic        hit4;
  logic        ret_bad;
  logic        tracks_on;
  logic        long_tape;
  tac_len_t    eff_len;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    r_next = r_reg;
    wr = psel_in && penable_in && pwrite_in;
    rd = psel_in && !penable_in && !pwrite_in;
    key = (wr && paddr_in == `TAC_ADDR_KEYS) ? pwdata_in[7:0] : 8'h00;
    // Pedal pins pass two flops; press is a departure from the resting level
    r_next.ped_s1 = {punch_pedal_in, locate_pedal_input};
    r_next.ped_s2 = r_reg.ped_s1;
    r_next.ped_prev = r_reg.ped_s2 ^ r_reg.ped_rest;
    punch_press = r_reg.calibrated && r_next.ped_prev[1] && !r_reg.ped_prev[1];
    locate_press = r_reg.calibrated && r_next.ped_prev[0] && !r_reg.ped_prev[0];
    // Rest level taken on third edge,
    // once pins have reached ped_s2;
    // ped_prev counts edges till then
    if (!r_reg.calibrated) begin
      r_next.ped_prev = r_reg.ped_prev + 2'd1;
      if (r_reg.ped_prev == 2'd2) begin
        r_next.ped_rest = r_reg.ped_s2;
        r_next.calibrated = 1'b1;
        r_next.ped_prev = 2'b00;
      end
    end
    r_next.pos_prev = xport_in.position;
    hit1 = at_or_past(r_reg.pos_prev, xport_in.position, r_reg.loc1);
    hit2 = at_or_past(r_reg.pos_prev, xport_in.position, r_reg.loc2);
    hit3 = at_or_past(r_reg.pos_prev, xport_in.position, r_reg.loc3);
    hit4 = at_or_past(r_reg.pos_prev, xport_in.position, r_reg.loc4);
    ret_bad = r_reg.loc1 > r_reg.loc4;
    tracks_on = |r_reg.tracks;
    eff_len = xport_in.large_hub ? TAC_LEN_60 : r_reg.len;
    long_tape = (eff_len == TAC_LEN_160) || (eff_len == TAC_LEN_180);
    r_next.relocate = 1'b0;

    // Message and flash timers
    if (r_reg.msg_cnt != 27'd0) begin
      r_next.msg_cnt = r_reg.msg_cnt - 27'd1;
    end else begin
      r_next.msg = TAC_MSG_NONE;
    end
    if (r_reg.flash_cnt == 24'd0) begin
      r_next.flash_cnt = 24'(`TAC_FLASH_CYCLES);
      r_next.flash = !r_reg.flash;
    end else begin
      r_next.flash_cnt = r_reg.flash_cnt - 24'd1;
    end

    // APB register writes
    if (wr) begin
      case (paddr_in)
        `TAC_ADDR_CTRL: begin
          r_next.ctrl = pwdata_in[4:0];
          r_next.ctrl[`TAC_CTRL_AUTOREC] = r_reg.ctrl[`TAC_CTRL_AUTOREC];
        end
        `TAC_ADDR_LOC1:   r_next.loc1 = pwdata_in;
        `TAC_ADDR_LOC2:   r_next.loc2 = pwdata_in;
        `TAC_ADDR_LOC3:   r_next.loc3 = pwdata_in;
        `TAC_ADDR_LOC4:   r_next.loc4 = pwdata_in;
        `TAC_ADDR_TRACKS: r_next.tracks = pwdata_in[7:0];
        default: ;
      endcase
    end

    // Panel keys
    if (key[`TAC_KEY_RETURN]) begin
      if (key[`TAC_KEY_STORE]) begin
        r_next.limit_off = 1'b1;
      end else begin
        r_next.ctrl[`TAC_CTRL_RETURN] = !r_reg.ctrl[`TAC_CTRL_RETURN];
        r_next.loop_dead = 1'b0;
      end
    end
    if (key[`TAC_KEY_AUTOPLAY]) begin
      if (key[`TAC_KEY_STORE]) begin
        if (r_reg.ctrl[`TAC_CTRL_RETURN] && r_reg.ctrl[`TAC_CTRL_AUTOPLAY]) begin
          r_next.msg = TAC_MSG_LOOPCNT;
          r_next.msg_cnt = 27'(`TAC_MSG_CYCLES);
        end
      end else begin
        r_next.ctrl[`TAC_CTRL_AUTOPLAY] = !r_reg.ctrl[`TAC_CTRL_AUTOPLAY];
      end
    end
    if (key[`TAC_KEY_AUTOREC]) begin
      if (r_reg.ctrl[`TAC_CTRL_AUTOREC]) begin
        r_next.ctrl[`TAC_CTRL_AUTOREC] = 1'b0;
      end else if (r_reg.loc2 >= r_reg.loc3) begin
        r_next.msg = TAC_MSG_INVALID;
        r_next.msg_cnt = 27'(`TAC_MSG_CYCLES);
      end else begin
        r_next.ctrl[`TAC_CTRL_AUTOREC] = 1'b1;
      end
    end
    if (key[`TAC_KEY_FORMAT] && key[`TAC_KEY_STORE]) begin
      case (r_reg.len)
        TAC_LEN_120: r_next.len = TAC_LEN_60;
        TAC_LEN_60:  r_next.len = TAC_LEN_160;
        TAC_LEN_160: r_next.len = TAC_LEN_180;
        default:     r_next.len = TAC_LEN_120;
      endcase
      r_next.msg = TAC_MSG_LENGTH;
      r_next.msg_cnt = 27'(`TAC_MSG_CYCLES);
    end
    // Length register has no eject path; only power-up reset clears it
    r_next.cass_q = xport_in.cassette_in;
    if (xport_in.cassette_in && !r_reg.cass_q && r_reg.len != TAC_LEN_120) begin
      r_next.msg = TAC_MSG_LENGTH;
      r_next.msg_cnt = 27'(`TAC_MSG_CYCLES);
    end
    if (key[`TAC_KEY_STOP]) begin
      r_next.mode = TAC_ST_STOP;
      r_next.limit_off = 1'b0;
    end
    if (key[`TAC_KEY_PLAY]) begin
      r_next.mode = TAC_ST_PLAY;
    end
    if (key[`TAC_KEY_RECPLAY]) begin
      r_next.mode = TAC_ST_PLAY;
      r_next.armed = r_reg.ctrl[`TAC_CTRL_AUTOREC];
      r_next.punched = 1'b0;
      if (!r_reg.ctrl[`TAC_CTRL_AUTOREC] && tracks_on) begin
        r_next.mode = TAC_ST_REC;
      end
    end

    // Pedals
    if (punch_press) begin
      if (r_reg.mode == TAC_ST_REC) begin
        r_next.mode = TAC_ST_PLAY;
      end else if (r_reg.mode == TAC_ST_PLAY && tracks_on) begin
        r_next.mode = TAC_ST_REC;
      end
    end
    if (locate_press) begin
      case (r_reg.mode)
        TAC_ST_STOP:   r_next.mode = TAC_ST_PLAY;
        TAC_ST_LOCATE: r_next.mode = TAC_ST_STOP;
        default: begin
          r_next.mode = TAC_ST_LOCATE;
          r_next.target = r_reg.loc1;
          r_next.relocate = 1'b1;
        end
      endcase
    end

    // Auto record in play
    if (r_reg.armed && r_reg.ctrl[`TAC_CTRL_AUTOREC]) begin
      if (r_reg.mode == TAC_ST_PLAY && !r_reg.punched &&
          xport_in.position >= r_reg.loc2 && xport_in.position < r_reg.loc3 &&
          xport_in.locked && tracks_on &&
          !(r_reg.ctrl[`TAC_CTRL_REHEARSE] && r_reg.ctrl[`TAC_CTRL_AUTOINPUT])) begin
        r_next.mode = TAC_ST_REC;
        r_next.punched = 1'b1;
      end
      if (hit3 && (r_reg.mode == TAC_ST_REC || r_reg.mode == TAC_ST_PLAY)) begin
        r_next.mode = TAC_ST_PLAY;
        r_next.armed = 1'b0;
      end
    end

    // Auto return and loop limit
    if (r_reg.ctrl[`TAC_CTRL_RETURN] && !r_reg.loop_dead && !ret_bad && hit4 &&
        (r_reg.mode == TAC_ST_PLAY || r_reg.mode == TAC_ST_REC)) begin
      r_next.mode = TAC_ST_LOCATE;
      r_next.target = r_reg.loc1;
      r_next.relocate = 1'b1;
      r_next.armed = r_reg.ctrl[`TAC_CTRL_AUTOREC];
      r_next.punched = 1'b0;
      r_next.loops = r_reg.loops + 7'd1;
      if (r_reg.loops + 7'd1 >= `TAC_LOOP_LIMIT && !r_reg.limit_off) begin
        r_next.loop_dead = 1'b1;
      end
    end
    if (r_reg.mode == TAC_ST_LOCATE && xport_in.locate_done && !r_reg.relocate) begin
      r_next.mode = r_reg.ctrl[`TAC_CTRL_AUTOPLAY] ? TAC_ST_PLAY : TAC_ST_STOP;
    end
    if (r_next.mode == TAC_ST_STOP || !r_next.ctrl[`TAC_CTRL_RETURN]) begin
      r_next.loops = 7'd0;
    end

    // Slow first long locate past the 39-minute mark
    if (r_next.relocate && long_tape && !r_reg.slowed_once &&
        r_next.target > `TAC_POS_39MIN) begin
      r_next.slowed_once = 1'b1;
      r_next.slow_cnt = 27'(`TAC_SLOW_CYCLES);
    end else if (r_reg.slow_cnt != 27'd0) begin
      r_next.slow_cnt = r_reg.slow_cnt - 27'd1;
    end

    // Outputs
    r_next.cmd.mode = r_next.mode;
    r_next.cmd.locate_target = r_next.target;
    r_next.cmd.slow = r_next.slow_cnt != 27'd0;
    r_next.cmd.rec_tracks = (r_next.mode == TAC_ST_REC) ? r_next.tracks : 8'h00;
    r_next.cmd.input_mon = 8'h00;
    if (r_reg.armed && r_reg.ctrl[`TAC_CTRL_REHEARSE] &&
        r_reg.ctrl[`TAC_CTRL_AUTOINPUT] &&
        xport_in.position >= r_reg.loc2 && xport_in.position < r_reg.loc3) begin
      r_next.cmd.input_mon = r_reg.tracks;
    end
    r_next.panel.return_led = r_next.ctrl[`TAC_CTRL_RETURN] &&
                              (!ret_bad || r_reg.flash);
    if (r_next.mode == TAC_ST_REC) begin
      r_next.panel.record_led = 1'b1;
    end else if (r_next.armed && r_next.mode == TAC_ST_PLAY) begin
      r_next.panel.record_led = r_reg.flash;
    end else begin
      r_next.panel.record_led = 1'b0;
    end
    r_next.panel.msg = r_next.msg;
    case (r_next.msg)
      TAC_MSG_LOOPCNT: r_next.panel.msg_value = {1'b0, r_next.loops};
      TAC_MSG_LENGTH:  r_next.panel.msg_value = len_code(r_next.len);
      default:         r_next.panel.msg_value = 8'h00;
    endcase

    // APB answer; reads sampled in setup, ready in access
    r_next.pready = psel_in && !penable_in;
    r_next.pslverr = 1'b0;
    if (rd) begin
      case (paddr_in)
        `TAC_ADDR_CTRL:    r_next.prdata = {27'h0, r_reg.ctrl};
        `TAC_ADDR_LOC1:    r_next.prdata = r_reg.loc1;
        `TAC_ADDR_LOC2:    r_next.prdata = r_reg.loc2;
        `TAC_ADDR_LOC3:    r_next.prdata = r_reg.loc3;
        `TAC_ADDR_LOC4:    r_next.prdata = r_reg.loc4;
        `TAC_ADDR_KEYS:    r_next.prdata = 32'h0;
        `TAC_ADDR_STATUS:  r_next.prdata = {22'h0, r_reg.limit_off, r_reg.loop_dead,
                                            r_reg.len, r_reg.armed, r_reg.punched,
                                            1'b0, r_reg.mode};
        `TAC_ADDR_LOOPCNT: r_next.prdata = {25'h0, r_reg.loops};
        `TAC_ADDR_TRACKS:  r_next.prdata = {24'h0, r_reg.tracks};
        default: begin
          r_next.prdata = 32'h0;
          r_next.pslverr = 1'b1;
        end
      endcase
    end else if (psel_in && !penable_in) begin
      r_next.prdata = 32'h0;
      r_next.pslverr = (paddr_in > `TAC_ADDR_TRACKS) || (paddr_in[1:0] != 2'b00);
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign prdata_out  = r_reg.prdata;
  assign pready_out  = r_reg.pready;
  assign pslverr_out = r_reg.pslverr;
  assign cmd_out     = r_reg.cmd;
  assign panel_out   = r_reg.panel;
endmodule // tac_top

/* bench/tac_props.sv */
// Port-level assertions for the transport automation controller
`timescale 1ns/1ps
module tac_props (
  input wire logic                clk_sys_in,  // Clock
  input wire logic                arst_n_in,   // Reset, active low
  input wire logic                psel_in,     // APB select
  input wire logic                penable_in,  // APB enable
  input wire logic                pwrite_in,   // APB write
  input wire logic [11:0]         paddr_in,    // APB address
  input wire logic [31:0]         pwdata_in,   // APB write data
  input wire logic                pready_out,  // APB ready
  input wire logic                pslverr_out, // APB error
  input wire tac_pkg::tac_xport_t xport_in,    // Transport status
  input wire tac_pkg::tac_cmd_t   cmd_out,     // Transport command
  input wire tac_pkg::tac_panel_t panel_out    // Panel outputs
);
  import tac_pkg::*;
  // ==========
  // Shadow copies, since points and tracks live inside
  logic [31:0] loc_q [1:4];
  logic [31:0] pos_q;
  logic [7:0]  trk_q;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      loc_q <= '{default: 32'h0};
      pos_q <= 32'h0;
      trk_q <= 8'h00;
    end else begin
      pos_q <= xport_in.position;
      if (psel_in && penable_in && pwrite_in && pready_out && !pslverr_out) begin
        if (paddr_in >= 12'h004 && paddr_in <= 12'h010)
          loc_q[paddr_in[4:2]] <= pwdata_in;
        if (paddr_in == 12'h020)
          trk_q <= pwdata_in[7:0];
      end
    end
  end
  function automatic logic crossed(input logic [31:0] p);
    return (pos_q < p) && (p <= xport_in.position);
  endfunction
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  // ==========
  // Assertions
  apb_answer_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("no ready in access cycle");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  bad_addr_a: assert property (psel_in && !penable_in
      && (paddr_in > 12'h020 || paddr_in[1:0] != 2'b00) |=> pslverr_out)
    else $error("bad address not refused");
  punch_wait_a: assert property (cmd_out.mode == TAC_ST_PLAY && !xport_in.locked
      && cmd_out.rec_tracks == 8'h00 |=> cmd_out.rec_tracks == 8'h00)
    else $error("recording started without lock");
  punch_out_a: assert property (cmd_out.mode == TAC_ST_REC && crossed(loc_q[3])
      |=> cmd_out.mode == TAC_ST_PLAY && cmd_out.rec_tracks == 8'h00 && !panel_out.record_led)
    else $error("no punch-out at end point");
  no_back_loop_a: assert property (cmd_out.mode == TAC_ST_PLAY && crossed(loc_q[4])
      && loc_q[1] > loc_q[4] |=> cmd_out.mode != TAC_ST_LOCATE)
    else $error("return with start after end");
  rec_led_a: assert property (cmd_out.rec_tracks != 8'h00 |-> panel_out.record_led)
    else $error("record lamp dark while recording");
  track_subset_a: assert property ((cmd_out.rec_tracks & ~trk_q) == 8'h00)
    else $error("recording a track not enabled");
  cover property (cmd_out.mode == TAC_ST_REC);
  cover property (panel_out.msg == TAC_MSG_INVALID);
  cover property (cmd_out.mode == TAC_ST_LOCATE ##1 cmd_out.mode == TAC_ST_STOP);
endmodule // tac_props
bind tac_top tac_props u_props (.clk_sys_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .xport_in, .cmd_out, .panel_out);

/* bench/tac_xport_model.sv */
// Behavioural tape transport facing the controller
`timescale 1ns/1ps
module tac_xport_model #(
  parameter int LOCK_DELAY = 50  // Play cycles before timecode lock
) (
  input  wire logic              clk_sys_in, // Clock
  input  wire logic              arst_n_in,  // Reset, active low
  input  wire tac_pkg::tac_cmd_t cmd_in,     // Controller command
  input  wire logic              cass_in,    // Cassette present
  output tac_pkg::tac_xport_t    xport_out   // Position and status
);
  import tac_pkg::*;
  logic [31:0] pos;
  int          lock_cnt;
  logic        moving;
  assign moving = cmd_in.mode == TAC_ST_PLAY || cmd_in.mode == TAC_ST_REC;
  // ==========
  // Lock comes late on purpose, so an early punch point must wait
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pos <= 32'h0;
      lock_cnt <= 0;
    end else begin
      lock_cnt <= moving ? ((lock_cnt < LOCK_DELAY) ? lock_cnt + 1 : lock_cnt) : 0;
      if (moving)
        pos <= pos + 32'h1;
      else if (cmd_in.mode == TAC_ST_LOCATE && pos != cmd_in.locate_target)
        pos <= (pos < cmd_in.locate_target) ? pos + 32'h1 : pos - 32'h1;
    end
  end
  assign xport_out.position = pos;
  assign xport_out.locked = lock_cnt == LOCK_DELAY;
  assign xport_out.locate_done = cmd_in.mode == TAC_ST_LOCATE && pos == cmd_in.locate_target;
  assign xport_out.cassette_in = cass_in;
  assign xport_out.large_hub = 1'b0;
endmodule // tac_xport_model

/* bench/tac_top_bench.sv */
// Self-checking bench for the transport automation controller
`timescale 1ns/1ps
`include "tac_map.svh"
module tac_top_bench;
  import tac_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  ped = 2'b11;
  tac_xport_t  xport;
  tac_cmd_t    cmd;
  tac_panel_t  panel;
  tac_mode_t   last_mode;
  int          errors = 0;
  int          samples_checked = 0;
  int          locates = 0;
  logic [31:0] q;
  logic [31:0] p;
  logic        e;
  always #12.5 clk_sys_in = ~clk_sys_in;
  tac_top dut (.clk_sys_in, .arst_n_in, .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .xport_in(xport), .punch_pedal_in(ped[0]),
    .locate_pedal_input(ped[1]), .cmd_out(cmd), .panel_out(panel));
  tac_xport_model model (.clk_sys_in, .arst_n_in, .cmd_in(cmd), .cass_in(1'b1),
    .xport_out(xport));
  always @(posedge clk_sys_in) begin
    if (cmd.mode === TAC_ST_LOCATE && last_mode !== TAC_ST_LOCATE)
      locates++;
    last_mode <= cmd.mode;
  end
  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic key(input logic [7:0] k);
    apb(1'b1, `TAC_ADDR_KEYS, {24'h0, k});
  endtask
  // Pedals rest high, so a press pulls the pin low
  task automatic press(input int i);
    ped[i] <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    ped[i] <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_regs();
    apb(1'b0, `TAC_ADDR_STATUS, 32'h0);
    chk(q, 32'h0, "status after reset");
    apb(1'b0, 12'h024, 32'h0);
    chk(32'(e), 32'h1, "unmapped error");
    apb(1'b1, `TAC_ADDR_LOC1, 32'h0000_1000);
    apb(1'b0, `TAC_ADDR_LOC1, 32'h0);
    chk(q, 32'h0000_1000, "point 1 readback");
    $display("test regs done");
  endtask
  task automatic t_length();
    logic [7:0] v [4] = '{8'd60, 8'd160, 8'd180, 8'd120};
    for (int i = 0; i < 4; i++) begin
      key(8'h88);
      apb(1'b0, `TAC_ADDR_STATUS, 32'h0);
      chk(32'(q[7:6]), 32'((i + 1) % 4), "length code");
      chk(32'(panel.msg), 32'(TAC_MSG_LENGTH), "length message");
      chk(32'(panel.msg_value), 32'(v[i]), "length shown");
    end
    $display("test length done");
  endtask
  task automatic t_invalid();
    apb(1'b1, `TAC_ADDR_LOC2, 32'd40);
    apb(1'b1, `TAC_ADDR_LOC3, 32'd40);
    key(8'h04);
    apb(1'b0, `TAC_ADDR_CTRL, 32'h0);
    chk(32'(q[2]), 32'h0, "auto record refused");
    chk(32'(panel.msg), 32'(TAC_MSG_INVALID), "invalid shown");
    $display("test invalid done");
  endtask
  task automatic t_autorec();
    apb(1'b1, `TAC_ADDR_LOC3, 32'd60);
    apb(1'b1, `TAC_ADDR_TRACKS, 32'h3);
    key(8'h04);
    apb(1'b0, `TAC_ADDR_CTRL, 32'h0);
    chk(32'(q[2]), 32'h1, "auto record armed");
    key(8'h40);
    for (int i = 0; i < 500 && cmd.rec_tracks !== 8'h03; i++)
      @(posedge clk_sys_in);
    chk(32'(xport.position > 32'd45), 32'h1, "punch-in waits for lock");
    chk(32'(cmd.mode), 32'(TAC_ST_REC), "recording");
    chk(32'(panel.record_led), 32'h1, "record lamp");
    for (int i = 0; i < 500 && cmd.mode !== TAC_ST_PLAY; i++)
      @(posedge clk_sys_in);
    chk(xport.position, 32'd61, "punch-out point");
    chk(32'(cmd.rec_tracks), 32'h0, "punch-out");
    $display("test autorec done");
  endtask
  task automatic t_loop();
    p = xport.position;
    key(8'h01);
    key(8'h02);
    apb(1'b1, `TAC_ADDR_LOC4, p + 32'd20);
    locates = 0;
    repeat (40) @(posedge clk_sys_in);
    chk(32'(locates), 32'h0, "no return");
    p = xport.position;
    apb(1'b1, `TAC_ADDR_LOC1, p + 32'd20);
    apb(1'b1, `TAC_ADDR_LOC4, p + 32'd28);
    locates = 0;
    for (int i = 0; i < 4000 && locates < 101; i++)
      @(posedge clk_sys_in);
    chk(32'(locates), 32'd100, "loops before limit");
    chk(cmd.locate_target, p + 32'd20, "return target");
    chk(32'(cmd.mode), 32'(TAC_ST_PLAY), "play after locate");
    key(8'h82);
    apb(1'b0, `TAC_ADDR_LOOPCNT, 32'h0);
    chk(q, 32'd100, "loop count");
    chk(32'(panel.msg_value), 32'd100, "count shown");
    key(8'h10);
    apb(1'b0, `TAC_ADDR_LOOPCNT, 32'h0);
    chk(q, 32'h0, "count cleared on stop");
    $display("test loop done");
  endtask
  task automatic t_pedal();
    apb(1'b1, `TAC_ADDR_LOC1, 32'h0);
    press(1);
    chk(32'(cmd.mode), 32'(TAC_ST_PLAY), "pedal play");
    repeat (60) @(posedge clk_sys_in);
    press(0);
    chk(32'(cmd.mode), 32'(TAC_ST_REC), "pedal punch in");
    chk(32'(cmd.rec_tracks), 32'h3, "tracks recording");
    press(0);
    chk(32'(cmd.mode), 32'(TAC_ST_PLAY), "pedal punch out");
    apb(1'b0, `TAC_ADDR_TRACKS, 32'h0);
    chk(q, 32'h3, "tracks kept");
    press(1);
    chk(32'(cmd.mode), 32'(TAC_ST_LOCATE), "pedal locate");
    chk(cmd.locate_target, 32'h0, "locate to point 1");
    press(1);
    chk(32'(cmd.mode), 32'(TAC_ST_STOP), "pedal stop");
    $display("test pedal done");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    t_regs();
    t_length();
    t_invalid();
    t_autorec();
    t_loop();
    t_pedal();
    final_report();
  end
  // Whole run needs under 8000 cycles
  initial begin
    #1000000;
    errors++;
    $display("BAD t=%0t watchdog expired", $time);
    final_report();
  end
endmodule // tac_top_bench
